//--- logic/adc_seq_pkg.sv
// Purpose: Shared constants and types for the converter sequencing control block
// Assumes: AXI4-Lite register access, 32-bit data, 16-bit registers in low bits
// Notes:   Offsets are byte addresses of aligned words
package adc_seq_pkg;

  // ==========================================================================
  // Register offsets
  localparam logic [7:0] timing_off     = 8'h00;
  localparam logic [7:0] dma_size_off   = 8'h04;
  localparam logic [7:0] scan_cmp_off   = 8'h08;
  localparam logic [7:0] chan_sel_off   = 8'h0c;
  localparam logic [7:0] buf_ctrl_off   = 8'h10;
  localparam logic [7:0] status_off     = 8'h14;

  // ==========================================================================
  // Field positions
  localparam int clk_src_bit    = 15;
  localparam int ext_sample_enable_bit   = 14;
  localparam int pump_bit       = 13;
  localparam int auto_sample_time_lsb       = 8;
  localparam int scan_en_bit    = 15;
  localparam int low_pwr_bit    = 14;
  localparam int ctm_req_bit    = 13;
  localparam int bg_req_bit     = 12;
  localparam int scan_interrupt_mode_lsb      = 8;
  localparam int wm_lsb         = 2;
  localparam int nb_lsb         = 13;
  localparam int sb_lsb         = 8;
  localparam int na_lsb         = 5;

  // Implemented-bit masks for each writable register
  localparam logic [15:0] timing_mask   = 16'hbfff;
  localparam logic [15:0] dma_size_mask = 16'h0007;
  localparam logic [15:0] scan_cmp_mask = 16'hf30f;
  localparam logic [15:0] chan_sel_mask = 16'hffff;
  localparam logic [15:0] buf_ctrl_mask = 16'h000f;

  // ==========================================================================
  // Reset values and sizes
  localparam logic [15:0] reg_reset     = 16'h0000;
  localparam logic [4:0]  half_words    = 5'h0d;
  localparam logic [4:0]  upper_base    = 5'h0c;
  localparam logic [4:0]  fifo_words    = 5'h1a;
  localparam logic [7:0]  div_max       = 8'h3f;
  localparam logic [4:0]  last_analog   = 5'h17;
  localparam logic [2:0]  neg_ref_code  = 3'h0;
  localparam logic [2:0]  neg_an1_code  = 3'h2;

  // AXI responses
  localparam logic [1:0]  resp_okay     = 2'h0;
  localparam logic [1:0]  resp_slverr   = 2'h2;

  typedef enum logic [1:0] {
    wm_legacy  = 2'b00,
    wm_save    = 2'b01,
    wm_compare = 2'b10,
    wm_rsvd    = 2'b11
  } write_mode_e;

  typedef enum logic [1:0] {
    cm_less    = 2'b00,
    cm_greater = 2'b01,
    cm_inside  = 2'b10,
    cm_outside = 2'b11
  } compare_mode_e;

  typedef enum logic [1:0] {
    cv_idle   = 2'b00,
    cv_sample = 2'b01,
    cv_conv   = 2'b10
  } conv_state_e;

  // Analog front-end selection passed to the multiplexer
  typedef struct packed {
    logic [4:0] positive_sel;
    logic [2:0] negative_sel;
    logic       positive_valid;
    logic       negative_valid;
    logic       has_result_buffer;
  } mux_sel_s;

  // Result store write request
  typedef struct packed {
    logic        valid;
    logic [4:0]  index;
    logic [11:0] data;
  } store_wr_s;

endpackage

//--- logic/adc_sequencing_control.sv
// Purpose: Register file and sequencing control of a successive-approximation converter
// Assumes: Converter core delivers results with conv_done pulses; threshold pairs from software
// Notes:   Result store lives here; compare references come from threshold inputs
//
// Overview of operation
// - Split mode: halves start at words 0 and 12, alternate fill
// - Single mode: 26-word buffer filled from zero
// - Fill mode and half status need non-indexed storage
// - Alternate sampling swaps A and B selections
// - Clock source bit picks RC or divided clock
// - Extended sampling flag shows sampling after clear
// - Pump enable bit drives switch charge pump
// - Auto-sample time counts conversion clock periods
// - Divider gives value plus one cycles, upper reserved
// - DMA size field allocates two-power words
// - DMA size used only with DMA, non-extended
// - Auto-scan enable bit turns scanning on
// - Low-power bit drops power after scan
// - Current source request while converter active
// - Band gap request while converter active
// - Scan interrupt mode selects interrupt cause
// - Write mode chooses save, compare or legacy
// - Window modes match outside or inside pair
// - Greater and less modes compare against reference
// - Negative select: reference or input one only
// - Positive select decodes inputs and internal sources
// - Sample A fields decode like Sample B
// - Indexed storage writes to channel location
`timescale 1ns/1ps
`default_nettype none
module adc_sequencing_control #(
  parameter int unsigned words = 26
) (
  // Clock and reset
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  // AXI4-Lite slave
  input  wire logic [7:0]                s_awaddr,
  input  wire logic                      s_awvalid,
  output logic                           s_awready,
  input  wire logic [31:0]               s_wdata,
  input  wire logic [3:0]                s_wstrb,
  input  wire logic                      s_wvalid,
  output logic                           s_wready,
  output logic [1:0]                     s_bresp,
  output logic                           s_bvalid,
  input  wire logic                      s_bready,
  input  wire logic [7:0]                s_araddr,
  input  wire logic                      s_arvalid,
  output logic                           s_arready,
  output logic [31:0]                    s_rdata,
  output logic [1:0]                     s_rresp,
  output logic                           s_rvalid,
  input  wire logic                      s_rready,
  // Converter core
  input  wire logic                      converter_on,
  input  wire logic                      sample_enable,
  input  wire logic                      extended_dma_enable,
  input  wire logic                      extended_buffer_mode,
  input  wire logic                      rc_clock_tick,
  input  wire logic                      conv_done,
  input  wire logic [11:0]               conv_result,
  input  wire logic                      scan_sequence_done,
  input  wire logic [11:0]               threshold_lo,
  input  wire logic [11:0]               threshold_hi,
  // Front-end controls
  output adc_seq_pkg::mux_sel_s          mux_sel,
  output logic                           conv_clock_tick,
  output logic                           sampling_active,
  output logic                           switch_pump_enable,
  output logic                           charge_time_current_source,
  output logic                           bandgap_enable,
  output logic                           low_power,
  output logic                           auto_scan_enable,
  output logic [7:0]                     dma_words_per_input,
  output logic                           scan_event,
  output logic                           compare_match,
  output adc_seq_pkg::store_wr_s         store_wr
);

  // ==========================================================================
  // Registers
  logic [15:0] timing;
  logic [15:0] dma_size;
  logic [15:0] scan_cmp;
  logic [15:0] chan_sel;
  logic [15:0] buf_ctrl;
  logic        extended_sampling_flag;
  logic        half_fill_status;
  logic [11:0] result_mem [words];

  wire         conv_clock_source_sel    = timing[adc_seq_pkg::clk_src_bit];
  wire  [4:0]  auto_sample_time         = timing[adc_seq_pkg::auto_sample_time_lsb +: 5];
  wire  [7:0]  conv_clock_divider       = timing[7:0];
  wire  [2:0]  dma_size_code            = dma_size[2:0];
  wire  [1:0]  scan_interrupt_mode      = scan_cmp[adc_seq_pkg::scan_interrupt_mode_lsb +: 2];
  wire  [1:0]  result_write_mode        = scan_cmp[adc_seq_pkg::wm_lsb +: 2];
  wire  [1:0]  compare_mode             = scan_cmp[1:0];
  wire         alternate_sampling_sel   = buf_ctrl[0];
  wire         split_fill_select        = buf_ctrl[1];
  wire         channel_indexed_store_en = buf_ctrl[2];

  // ==========================================================================
  // AXI4-Lite slave: address and data taken in either order
  logic        aw_held;
  logic        w_held;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  wire         do_write = aw_held && w_held && !s_bvalid;

  assign s_awready = !aw_held && !s_bvalid;
  assign s_wready  = !w_held && !s_bvalid;
  assign s_arready = !s_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 8'h00;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
    end else begin
      if (s_awvalid && s_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_awaddr;
      end else if (do_write) begin
        aw_held <= 1'b0;
      end
      if (s_wvalid && s_wready) begin
        w_held <= 1'b1;
        w_data <= s_wdata;
        w_strb <= s_wstrb;
      end else if (do_write) begin
        w_held <= 1'b0;
      end
    end
  end

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] mask);
    logic [15:0] v;
    v = old;
    if (w_strb[0]) v[7:0] = w_data[7:0];
    if (w_strb[1]) v[15:8] = w_data[15:8];
    return v & mask;
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    return a == adc_seq_pkg::timing_off || a == adc_seq_pkg::dma_size_off ||
           a == adc_seq_pkg::scan_cmp_off || a == adc_seq_pkg::chan_sel_off ||
           a == adc_seq_pkg::buf_ctrl_off || a == adc_seq_pkg::status_off;
  endfunction

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_bvalid <= 1'b0;
      s_bresp  <= adc_seq_pkg::resp_okay;
    end else if (do_write) begin
      s_bvalid <= 1'b1;
      s_bresp  <= mapped(aw_addr) ? adc_seq_pkg::resp_okay : adc_seq_pkg::resp_slverr;
    end else if (s_bready) begin
      s_bvalid <= 1'b0;
    end
  end

  // Unimplemented bits are masked on write and read zero, except timing bit 14, which shows the extended sampling flag
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timing   <= adc_seq_pkg::reg_reset;
      dma_size <= adc_seq_pkg::reg_reset;
      scan_cmp <= adc_seq_pkg::reg_reset;
      chan_sel <= adc_seq_pkg::reg_reset;
      buf_ctrl <= adc_seq_pkg::reg_reset;
    end else if (do_write) begin
      case (aw_addr)
        adc_seq_pkg::timing_off:   timing   <= merge(timing, adc_seq_pkg::timing_mask);
        adc_seq_pkg::dma_size_off: dma_size <= merge(dma_size, adc_seq_pkg::dma_size_mask);
        adc_seq_pkg::scan_cmp_off: scan_cmp <= merge(scan_cmp, adc_seq_pkg::scan_cmp_mask);
        adc_seq_pkg::chan_sel_off: chan_sel <= merge(chan_sel, adc_seq_pkg::chan_sel_mask);
        adc_seq_pkg::buf_ctrl_off: buf_ctrl <= merge(buf_ctrl, adc_seq_pkg::buf_ctrl_mask);
        default: ;
      endcase
    end
  end

  logic [15:0] rd_word;
  always_comb begin
    case (s_araddr)
      adc_seq_pkg::timing_off:   rd_word = timing | 16'(extended_sampling_flag) << adc_seq_pkg::ext_sample_enable_bit;
      adc_seq_pkg::dma_size_off: rd_word = dma_size;
      adc_seq_pkg::scan_cmp_off: rd_word = scan_cmp;
      adc_seq_pkg::chan_sel_off: rd_word = chan_sel;
      adc_seq_pkg::buf_ctrl_off: rd_word = buf_ctrl;
      adc_seq_pkg::status_off:   rd_word = {15'h0000, half_fill_status};
      default:                   rd_word = 16'h0000;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_rvalid <= 1'b0;
      s_rdata  <= 32'h0000_0000;
      s_rresp  <= adc_seq_pkg::resp_okay;
    end else if (s_arvalid && s_arready) begin
      s_rvalid <= 1'b1;
      s_rdata  <= {16'h0000, rd_word};
      s_rresp  <= mapped(s_araddr) ? adc_seq_pkg::resp_okay : adc_seq_pkg::resp_slverr;
    end else if (s_rready) begin
      s_rvalid <= 1'b0;
    end
  end

  // ==========================================================================
  // Conversion clock: reserved divider codes saturate at the largest legal one
  logic [7:0] div_count;
  wire  [7:0] div_eff = (conv_clock_divider > adc_seq_pkg::div_max) ? adc_seq_pkg::div_max
                                                                     : conv_clock_divider;
  logic       sys_tick;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_count <= 8'h00;
      sys_tick  <= 1'b0;
    end else if (div_count >= div_eff) begin
      div_count <= 8'h00;
      sys_tick  <= 1'b1;
    end else begin
      div_count <= div_count + 8'h01;
      sys_tick  <= 1'b0;
    end
  end
  assign conv_clock_tick = conv_clock_source_sel ? rc_clock_tick : sys_tick;

  // ==========================================================================
  // Sampling timer and extended sampling flag
  logic [4:0] sample_enable_count;
  logic       sample_enable_running;
  logic       sample_enable_d;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sample_enable_running    <= 1'b0;
      sample_enable_count      <= 5'h00;
      sample_enable_d <= 1'b0;
    end else begin
      sample_enable_d <= sample_enable;
      if (sample_enable && !sample_enable_d) begin
        sample_enable_running <= auto_sample_time != 5'h00;
        sample_enable_count   <= auto_sample_time;
      end else if (sample_enable_running && conv_clock_tick) begin
        sample_enable_count   <= sample_enable_count - 5'h01;
        sample_enable_running <= sample_enable_count != 5'h01;
      end
    end
  end
  assign sampling_active = sample_enable || sample_enable_running;

  always_ff @(posedge aclk) begin
    if (!aresetn) extended_sampling_flag <= 1'b0;
    else extended_sampling_flag <= !sample_enable && sample_enable_running;
  end

  // ==========================================================================
  // Static controls
  wire active = converter_on && sampling_active;
  assign switch_pump_enable         = timing[adc_seq_pkg::pump_bit];
  assign auto_scan_enable           = scan_cmp[adc_seq_pkg::scan_en_bit];
  assign charge_time_current_source = scan_cmp[adc_seq_pkg::ctm_req_bit] && active;
  assign bandgap_enable             = scan_cmp[adc_seq_pkg::bg_req_bit] && active;
  assign dma_words_per_input = (extended_dma_enable && !extended_buffer_mode)
                               ? 8'h01 << dma_size_code : 8'h00;

  always_ff @(posedge aclk) begin
    if (!aresetn) low_power <= 1'b0;
    else if (scan_sequence_done) low_power <= scan_cmp[adc_seq_pkg::low_pwr_bit];
    else if (sample_enable) low_power <= 1'b0;
  end

  // ==========================================================================
  // Input selection: alternating A/B
  logic use_b;
  always_ff @(posedge aclk) begin
    if (!aresetn) use_b <= 1'b0;
    else if (!alternate_sampling_sel) use_b <= 1'b0;
    else if (conv_done) use_b <= !use_b;
  end

  wire [4:0] pos_code = use_b ? chan_sel[adc_seq_pkg::sb_lsb +: 5] : chan_sel[4:0];
  wire [2:0] neg_code = use_b ? chan_sel[adc_seq_pkg::nb_lsb +: 3] : chan_sel[adc_seq_pkg::na_lsb +: 3];
  always_comb begin
    mux_sel.positive_sel      = pos_code;
    mux_sel.negative_sel      = neg_code;
    mux_sel.positive_valid    = 1'b1;
    mux_sel.has_result_buffer = pos_code <= adc_seq_pkg::last_analog + 5'h02;
    mux_sel.negative_valid    = neg_code == adc_seq_pkg::neg_ref_code ||
                                neg_code == adc_seq_pkg::neg_an1_code;
  end

  // ==========================================================================
  // Compare and result store
  logic match;
  always_comb begin
    case (compare_mode)
      adc_seq_pkg::cm_less:    match = conv_result < threshold_lo;
      adc_seq_pkg::cm_greater: match = conv_result > threshold_lo;
      adc_seq_pkg::cm_inside:  match = conv_result >= threshold_lo && conv_result <= threshold_hi;
      adc_seq_pkg::cm_outside: match = conv_result < threshold_lo || conv_result > threshold_hi;
      default:                 match = 1'b0;
    endcase
  end

  logic [4:0] fill_ptr;
  logic       do_store;
  always_comb begin
    case (result_write_mode)
      adc_seq_pkg::wm_legacy: do_store = conv_done;
      adc_seq_pkg::wm_save:   do_store = conv_done && match;
      default:                do_store = 1'b0;
    endcase
  end
  wire       split_active = split_fill_select && !channel_indexed_store_en;
  wire [4:0] fifo_index   = (split_active && half_fill_status) ? adc_seq_pkg::upper_base + fill_ptr : fill_ptr;
  wire [4:0] store_index  = channel_indexed_store_en ? pos_code : fifo_index;
  wire [4:0] fill_limit   = split_active ? adc_seq_pkg::half_words : adc_seq_pkg::fifo_words;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fill_ptr         <= 5'h00;
      half_fill_status <= 1'b0;
    end else if (!split_active) begin
      half_fill_status <= 1'b0;
      if (do_store && !channel_indexed_store_en)
        fill_ptr <= (fill_ptr + 5'h01 >= fill_limit) ? 5'h00 : fill_ptr + 5'h01;
    end else if (do_store) begin
      fill_ptr         <= 5'h00;
      half_fill_status <= !half_fill_status;
    end
  end

  always_ff @(posedge aclk) begin
    if (do_store && store_index < 5'(words))
      result_mem[store_index] <= conv_result;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) store_wr <= '0;
    else store_wr <= '{valid: do_store, index: store_index, data: conv_result};
  end

  // ==========================================================================
  // Scan interrupt cause
  logic match_seen;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      compare_match <= 1'b0;
      match_seen    <= 1'b0;
      scan_event    <= 1'b0;
    end else begin
      compare_match <= conv_done && match;
      if (scan_sequence_done) match_seen <= 1'b0;
      else if (conv_done && match) match_seen <= 1'b1;
      case (scan_interrupt_mode)
        2'b01:   scan_event <= scan_sequence_done;
        2'b10:   scan_event <= conv_done && match;
        2'b11:   scan_event <= scan_sequence_done && (match_seen || (conv_done && match));
        default: scan_event <= 1'b0;
      endcase
    end
  end

  // ==========================================================================
  // Assertions
  sequence stored_s;
    do_store && !channel_indexed_store_en && !split_active;
  endsequence

  split_upper_a: assert property (@(posedge aclk) disable iff (!aresetn)
    split_active && half_fill_status && do_store |-> store_index == adc_seq_pkg::upper_base)
    else $error("split upper half base wrong");
  fifo_wrap_a: assert property (@(posedge aclk) disable iff (!aresetn)
    stored_s ##0 fill_ptr == adc_seq_pkg::fifo_words - 5'h01 |=> fill_ptr == 5'h00)
    else $error("single buffer did not wrap at 26");
  half_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
    channel_indexed_store_en |=> !half_fill_status)
    else $error("half status set under indexed storage");
  alt_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !alternate_sampling_sel |=> mux_sel.positive_sel == chan_sel[4:0])
    else $error("sample B used without alternation");
  ext_sample_enable_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !sample_enable && sample_enable_running |=> extended_sampling_flag)
    else $error("extended sampling flag missing");
  div_period_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(sys_tick) && $stable(timing) && div_eff == 8'h01 |-> ##2 sys_tick)
    else $error("divider period wrong");
  dma_ignore_a: assert property (@(posedge aclk) disable iff (!aresetn)
    extended_buffer_mode |-> dma_words_per_input == 8'h00)
    else $error("dma size honoured in extended mode");
  cmp_store_a: assert property (@(posedge aclk) disable iff (!aresetn)
    result_write_mode == adc_seq_pkg::wm_compare && conv_done |=> !store_wr.valid)
    else $error("compare-only mode stored a result");
  neg_valid_a: assert property (@(posedge aclk) disable iff (!aresetn)
    mux_sel.negative_valid |-> mux_sel.negative_sel inside {3'h0, 3'h2})
    else $error("unimplemented negative input accepted");

endmodule
`default_nettype wire

//--- dv/conv_core_model.sv
// Purpose: Behavioural converter core on the far side of the control block
// Assumes: start is a one-cycle request made by the bench
// Notes:   Result lines flip each idle cycle so stale data never looks valid
`timescale 1ns/1ps
`default_nettype none
module conv_core_model (
  // Clock
  input  wire logic        aclk,
  // Requests
  input  wire logic        start,
  input  wire logic [11:0] value,
  // Core outputs
  output logic             conv_done,
  output logic [11:0]      conv_result,
  output logic             rc_clock_tick
);
  // ==========================================================================
  // Core timing
  logic [2:0] rc_cnt = 3'h0;
  initial begin
    conv_done = 1'b0;
    conv_result = 12'h000;
    rc_clock_tick = 1'b0;
  end
  always @(posedge aclk) begin
    conv_done <= start;
    conv_result <= start ? value : ~conv_result;
    rc_cnt <= rc_cnt + 3'h1;
    rc_clock_tick <= (rc_cnt == 3'h4);
  end
endmodule
`default_nettype wire

//--- dv/adc_sequencing_control_test.sv
// Purpose: Self-checking bench for the converter sequencing control block
// Assumes: Response ready lines held high, so every answer is taken at once
// Notes:   Reset is pulsed three times to see a mid-run release
`timescale 1ns/1ps
`default_nettype none
module adc_sequencing_control_test;
  // ==========================================================================
  // Signals
  logic aclk = 1'b0, aresetn = 1'b0, start = 1'b0;
  logic [7:0] s_awaddr = 8'h00, s_araddr = 8'h00, dma_words_per_input;
  logic [31:0] s_wdata = 32'h0, s_rdata;
  logic [3:0] s_wstrb = 4'h3;
  logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_arvalid = 1'b0, s_bready = 1'b1, s_rready = 1'b1;
  logic converter_on = 1'b0, sample_enable = 1'b0, extended_dma_enable = 1'b0, extended_buffer_mode = 1'b0;
  logic scan_sequence_done = 1'b0, conv_done, rc_clock_tick;
  logic [11:0] value = 12'h0, conv_result, threshold_lo = 12'h100, threshold_hi = 12'h800;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, conv_clock_tick, sampling_active;
  logic switch_pump_enable, charge_time_current_source, bandgap_enable, low_power, auto_scan_enable;
  logic scan_event, compare_match;
  logic [1:0] s_bresp, s_rresp;
  adc_seq_pkg::mux_sel_s mux_sel;
  adc_seq_pkg::store_wr_s store_wr;
  int error_cnt = 0;
  int num_checks = 0;
  always #25 aclk = ~aclk;
  conv_core_model i_conv_core_model (.aclk, .start, .value, .conv_done, .conv_result, .rc_clock_tick);
  adc_sequencing_control i_adc_sequencing_control (.aclk, .aresetn, .s_awaddr, .s_awvalid, .s_awready,
    .s_wdata, .s_wstrb, .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid,
    .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready, .converter_on, .sample_enable,
    .extended_dma_enable, .extended_buffer_mode, .rc_clock_tick, .conv_done, .conv_result,
    .scan_sequence_done, .threshold_lo, .threshold_hi, .mux_sel, .conv_clock_tick, .sampling_active,
    .switch_pump_enable, .charge_time_current_source, .bandgap_enable, .low_power, .auto_scan_enable,
    .dma_words_per_input, .scan_event, .compare_match, .store_wr);
  // ==========================================================================
  // Shared tasks
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rst();
    aresetn <= 1'b0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    s_awaddr <= a;
    s_wdata <= {16'h0000, d};
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_awready) s_awvalid <= 1'b0;
      if (s_wready) s_wvalid <= 1'b0;
    end while (!s_bvalid);
    chk("write response", adc_seq_pkg::resp_okay, s_bresp);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_arready) s_arvalid <= 1'b0;
    end while (!s_rvalid);
    chk("read data", e, s_rdata);
    chk("read response", r, s_rresp);
  endtask
  task automatic conv(input logic [11:0] v, input logic [4:0] ei);
    int n;
    value <= v;
    start <= 1'b1;
    @(posedge aclk);
    start <= 1'b0;
    for (n = 0; n < 20 && store_wr.valid !== 1'b1; n++) @(posedge aclk);
    chk("store valid", 1, store_wr.valid);
    chk("store index", ei, store_wr.index);
    chk("store data", v, store_wr.data);
  endtask
  task automatic ticks(input logic [15:0] t, input int e);
    int n = 0;
    wr(adc_seq_pkg::timing_off, t);
    repeat (16) begin
      @(posedge aclk);
      n += conv_clock_tick;
    end
    chk("ticks", e, n);
  endtask
  task automatic cmp(input logic [15:0] m, input logic [11:0] v, input logic [2:0] e);
    wr(adc_seq_pkg::scan_cmp_off, m);
    value <= v;
    start <= 1'b1;
    @(posedge aclk);
    start <= 1'b0;
    repeat (2) @(posedge aclk);
    chk("match", e[2], compare_match);
    chk("stored", e[1], store_wr.valid);
    chk("event", e[0], scan_event);
  endtask
  task automatic summarize();
    $display("Checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // ==========================================================================
  // Scenarios
  task automatic t_regs();
    for (int i = 0; i < 6; i++) rchk(8'(i * 4), 32'h0, adc_seq_pkg::resp_okay);
    rchk(8'h18, 32'h0, adc_seq_pkg::resp_slverr);
    wr(adc_seq_pkg::timing_off, 16'hffff);
    rchk(adc_seq_pkg::timing_off, {16'h0, adc_seq_pkg::timing_mask}, 2'h0);
    chk("pump on", 1, switch_pump_enable);
    wr(adc_seq_pkg::timing_off, 16'h0000);
    chk("pump off", 0, switch_pump_enable);
    ticks(16'h0001, 8);
    ticks(16'h8001, 2);
    ticks(16'h1f00, 16);
    sample_enable <= 1'b1;
    @(posedge aclk);
    sample_enable <= 1'b0;
    repeat (2) @(posedge aclk);
    chk("sampling", 1, sampling_active);
    rchk(adc_seq_pkg::timing_off, 32'h5f00, 2'h0);
    repeat (40) @(posedge aclk);
    rchk(adc_seq_pkg::timing_off, 32'h1f00, 2'h0);
    $display("Test registers done");
  endtask
  task automatic t_ctrl();
    wr(adc_seq_pkg::dma_size_off, 16'hfffb);
    rchk(adc_seq_pkg::dma_size_off, 32'h3, 2'h0);
    extended_dma_enable <= 1'b1;
    @(posedge aclk);
    chk("dma words", 8, dma_words_per_input);
    extended_buffer_mode <= 1'b1;
    @(posedge aclk);
    chk("dma ignored", 0, dma_words_per_input);
    wr(adc_seq_pkg::scan_cmp_off, 16'hb000);
    chk("scan enable", 1, auto_scan_enable);
    chk("bandgap idle", 0, bandgap_enable);
    converter_on <= 1'b1;
    sample_enable <= 1'b1;
    @(posedge aclk);
    chk("bandgap active", 1, bandgap_enable);
    chk("current source", 1, charge_time_current_source);
    wr(adc_seq_pkg::chan_sel_off, 16'h0038);
    chk("positive sel", 5'h18, mux_sel.positive_sel);
    chk("negative bad", 0, mux_sel.negative_valid);
    chk("temp buffer", 1, mux_sel.has_result_buffer);
    wr(adc_seq_pkg::chan_sel_off, 16'h005a);
    chk("negative an1", 1, mux_sel.negative_valid);
    chk("ref no buffer", 0, mux_sel.has_result_buffer);
    $display("Test controls done");
  endtask
  task automatic t_store();
    rst();
    conv(12'h123, 5'h00);
    conv(12'h456, 5'h01);
    for (int i = 2; i < 27; i++) conv(12'(i), 5'(i % 26));
    rst();
    wr(adc_seq_pkg::buf_ctrl_off, 16'h0002);
    conv(12'h0a5, 5'h00);
    conv(12'h05a, adc_seq_pkg::upper_base);
    conv(12'hfff, 5'h00);
    wr(adc_seq_pkg::buf_ctrl_off, 16'h0004);
    wr(adc_seq_pkg::chan_sel_off, 16'h0005);
    conv(12'h321, 5'h05);
    $display("Test store done");
  endtask
  task automatic t_cmp();
    cmp(16'h0208, 12'h050, 3'b101);
    cmp(16'h0205, 12'h050, 3'b000);
    cmp(16'h0206, 12'h400, 3'b111);
    cmp(16'h0207, 12'h400, 3'b000);
    cmp(16'h0207, 12'h900, 3'b111);
    cmp(16'h4305, 12'h200, 3'b110);
    scan_sequence_done <= 1'b1;
    @(posedge aclk);
    scan_sequence_done <= 1'b0;
    @(posedge aclk);
    chk("scan event", 1, scan_event);
    chk("low power", 1, low_power);
    wr(adc_seq_pkg::buf_ctrl_off, 16'h0001);
    wr(adc_seq_pkg::chan_sel_off, 16'h0a05);
    cmp(16'h0000, 12'h000, 3'b110);
    chk("sample B", 5'h0a, mux_sel.positive_sel);
    $display("Test compare done");
  endtask
  initial begin
    rst();
    t_regs();
    t_ctrl();
    t_store();
    t_cmp();
    summarize();
  end
  initial begin
    #(50 * 4000);
    error_cnt++;
    summarize();
  end
endmodule
`default_nettype wire
